// >>> design/option_byte_config_decode.sv
// Option byte store and decoder for the microcontroller hardware configuration.
// Assumes an outside programming tool drives the programming port only while
// prog_mode is high, and that downstream blocks take the decoded levels as is.
// Functional notes
// - Watchdog-halt bit one resets on Halt entry.
// - Type bit zero forces watchdog always on.
// - Detect code picks threshold; eleven disables both.
// - Protection bit zero blocks readout and writes.
// - Protected option erase wipes program memory first.
// - Option bytes reachable only in programming mode.
// - Erased memory reads all ones.
// - Delivered parts select internal RC clock.
// - Mask variants ignore programming port writes.
// - Package bit selects pinout; unbonded pads pulled up.
// - Reset-delay bit picks 4096 or 256 cycles.
// - Clock field selects resonator, RC or external.
// - Erased option bytes take their documented defaults.
`timescale 1ns/1ns
module option_byte_config_decode #(
    parameter bit MASK_VARIANT = 1'b0,
    parameter logic [7:0] MASK_OB0 = option_cfg_pkg::OB0_DEFAULT,
    parameter logic [7:0] MASK_OB1 = option_cfg_pkg::ERASED_BYTE,
    parameter bit PKG_DEFAULT = 1'b1,
    parameter int PORT_PADS = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic prog_mode,
    input wire logic opt_sel,
    input wire logic opt_wr,
    input wire logic [7:0] opt_wdata,
    input wire logic opt_erase,
    input wire logic opt_rd,
    output logic [7:0] opt_rdata,
    output logic opt_busy,
    output logic mem_erase_req,
    input wire logic mem_erase_done,
    input wire logic halt_entry,
    input wire logic halt_exit,
    input wire logic watchdog_running,
    input wire logic [PORT_PADS-1:0] pad_bonded,
    output logic watchdog_halt_reset,
    output logic watchdog_force_on,
    output logic low_supply_reset_detector_en,
    output logic auxiliary_supply_detector_en,
    output logic [1:0] voltage_detect_level,
    output logic readout_block,
    output logic memory_write_block,
    output logic package_select_opt,
    output logic [PORT_PADS-1:0] pad_pullup_force,
    output logic [1:0] clock_source_type,
    output logic sel_resonator,
    output logic sel_internal_rc,
    output logic sel_external_clk,
    output logic [2:0] resonator_band,
    output logic [3:0] resonator_drive,
    output logic doubler_enable,
    output logic reset_delay_select,
    output logic reset_phase_active
);

    // ****************************************************************
    // Elaboration check.
    // ****************************************************************
    if (PORT_PADS < 1) begin : g_bad
        $error("PORT_PADS must be at least one.");
    end

    typedef enum logic [1:0] {
        IDLE,
        WIPE_MEMORY,
        WIPE_OPTIONS
    } erase_state_e;

    // Non-volatile copies, written from the programming port, or from the mask bytes in mask variants.
    // delivered with RC
    // The store powers up erased, as delivered; reset leaves it alone.
    logic [7:0] nv_ob0_r = option_cfg_pkg::OB0_DEFAULT;
    logic [7:0] nv_ob1_r = {PKG_DEFAULT, option_cfg_pkg::OB1_DEFAULT_LOW7[6:0]};
    // Configuration latches, loaded only around reset.
    logic [7:0] cfg_ob0_r;
    logic [7:0] cfg_ob1_r;
    logic [7:0] opt_rdata_r;
    logic [PORT_PADS-1:0] pad_pullup_r;
    logic in_reset_r;
    logic capture_r;
    logic halt_reset_r;
    erase_state_e erase_state_r;
    erase_state_e erase_state_nxt;

    logic [7:0] ob1_default;
    logic port_open;
    logic write_ob0;
    logic write_ob1;
    logic erase_start;
    logic erase_options;
    logic prot_selected;
    logic [7:0] rd_sel;
    logic phase_start;

    // ****************************************************************
    // Programming port decode.
    // ****************************************************************

    assign ob1_default = {PKG_DEFAULT, option_cfg_pkg::OB1_DEFAULT_LOW7[6:0]};
    assign port_open = prog_mode && !MASK_VARIANT && (erase_state_r == IDLE);
    assign write_ob0 = port_open && opt_wr && (opt_sel == option_cfg_pkg::OPT_SEL_ZERO);
    assign write_ob1 = port_open && opt_wr && (opt_sel == option_cfg_pkg::OPT_SEL_ONE);
    assign erase_start = port_open && opt_erase;
    assign prot_selected = !nv_ob0_r[option_cfg_pkg::OB0_PROT_BIT];
    assign erase_options = (erase_state_r == WIPE_OPTIONS);
    assign rd_sel = (opt_sel == option_cfg_pkg::OPT_SEL_ONE) ? nv_ob1_r : nv_ob0_r;
    assign opt_busy = (erase_state_r != IDLE);
    assign opt_rdata = opt_rdata_r;

    always_comb begin
        erase_state_nxt = erase_state_r;
        unique case (erase_state_r)
            IDLE: begin
                if (erase_start) begin
                    erase_state_nxt = prot_selected ? WIPE_MEMORY : WIPE_OPTIONS;
                end
            end
            WIPE_MEMORY: begin
                if (mem_erase_done) begin
                    erase_state_nxt = WIPE_OPTIONS;
                end
            end
            WIPE_OPTIONS: begin
                erase_state_nxt = IDLE;
            end
            default: begin
                erase_state_nxt = IDLE;
            end
        endcase
    end
    // Held as a level so a slow wipe can take as long as it needs.
    assign mem_erase_req = (erase_state_r == WIPE_MEMORY);

    // Erase sequencer state.
    // A reset in mid-erase drops the sequence; the store keeps what it held.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            erase_state_r <= IDLE;
        end else begin
            erase_state_r <= erase_state_nxt;
        end
    end

    // Non-volatile store; reset does not touch it, it starts erased.
    // erase restores defaults
    always_ff @(posedge core_clk) begin
        if (MASK_VARIANT) begin
            nv_ob0_r <= MASK_OB0;
            nv_ob1_r <= MASK_OB1;
        end else if (erase_options) begin
            nv_ob0_r <= option_cfg_pkg::OB0_DEFAULT;
            nv_ob1_r <= ob1_default;
        end else begin
            if (write_ob0) begin
                nv_ob0_r <= opt_wdata;
            end
            if (write_ob1) begin
                nv_ob1_r <= opt_wdata;
            end
        end
    end

    // Read data only answers in programming mode; otherwise it reads all ones.
    // hidden outside programming
    always_ff @(posedge core_clk) begin
        if (rst) begin
            opt_rdata_r <= option_cfg_pkg::ERASED_BYTE;
        end else if (opt_rd && prog_mode) begin
            opt_rdata_r <= rd_sel;
        end else begin
            opt_rdata_r <= option_cfg_pkg::ERASED_BYTE;
        end
    end

    // ****************************************************************
    // Configuration latches and reset phase.
    // ****************************************************************

    // The latches load in the first cycle after reset releases, so the next program takes
    // effect only through a reset, never mid-run.
    // latch after reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_ob0_r <= option_cfg_pkg::OB0_DEFAULT;
            cfg_ob1_r <= option_cfg_pkg::ERASED_BYTE;
            in_reset_r <= 1'b1;
            capture_r <= 1'b1;
        end else begin
            if (capture_r) begin
                cfg_ob0_r <= nv_ob0_r;
                cfg_ob1_r <= nv_ob1_r;
            end
            capture_r <= 1'b0;
            // The reset flag outlives the capture by one cycle, so the
            // counter start lands just after the latches load; dropping
            // both flags together would never start the reset phase.
            in_reset_r <= capture_r;
        end
    end

    // The delay counter starts after the latches hold the copied bytes.
    assign phase_start = (in_reset_r && !capture_r) || halt_exit;

    reset_phase_counter #(
        .LONG_CYCLES(option_cfg_pkg::RESET_CYCLES_LONG),
        .SHORT_CYCLES(option_cfg_pkg::RESET_CYCLES_SHORT)
    ) u_phase (
        .core_clk(core_clk),
        .rst(rst),
        .start(phase_start),
        .use_short(cfg_ob1_r[option_cfg_pkg::OB1_RESET_DELAY_SELECT_BIT]),
        .busy(reset_phase_active)
    );
    // The same latched bit sets both the reset and the Halt exit phase.
    assign reset_delay_select = cfg_ob1_r[option_cfg_pkg::OB1_RESET_DELAY_SELECT_BIT];

    // ****************************************************************
    // Decoded configuration.
    // ****************************************************************

    // The pulse is registered so the reset logic sees a clean one-cycle request.
    // halt reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            halt_reset_r <= 1'b0;
        end else begin
            halt_reset_r <= halt_entry && watchdog_running &&
                cfg_ob0_r[option_cfg_pkg::OB0_WATCHDOG_HALT_RESET_OPT_BIT];
        end
    end
    assign watchdog_halt_reset = halt_reset_r;

    assign watchdog_force_on = !cfg_ob0_r[option_cfg_pkg::OB0_WDG_TYPE_BIT];

    // Both detectors share one enable, so they switch on and off together.
    // voltage detect
    assign voltage_detect_level =
        cfg_ob0_r[option_cfg_pkg::OB0_VD_HI:option_cfg_pkg::OB0_VD_LO];
    assign low_supply_reset_detector_en = (voltage_detect_level != option_cfg_pkg::VD_OFF);
    assign auxiliary_supply_detector_en = (voltage_detect_level != option_cfg_pkg::VD_OFF);

    // Both blocks follow the same latched bit, so they can never disagree.
    // protection outputs
    assign readout_block = !cfg_ob0_r[option_cfg_pkg::OB0_PROT_BIT];
    assign memory_write_block = !cfg_ob0_r[option_cfg_pkg::OB0_PROT_BIT];

    // Registered so a changing bond strap never glitches the pull-up enables.
    // package and pads
    assign package_select_opt = cfg_ob1_r[option_cfg_pkg::OB1_PKG_BIT];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pad_pullup_r <= '1;
        end else begin
            pad_pullup_r <= ~pad_bonded;
        end
    end
    assign pad_pullup_force = pad_pullup_r;

    assign clock_source_type =
        cfg_ob1_r[option_cfg_pkg::OB1_CLK_HI:option_cfg_pkg::OB1_CLK_LO];
    assign sel_resonator = (clock_source_type == option_cfg_pkg::CLK_RESONATOR);
    assign sel_internal_rc = (clock_source_type == option_cfg_pkg::CLK_INTERNAL_RC);
    assign sel_external_clk = (clock_source_type == option_cfg_pkg::CLK_EXTERNAL);

    // resonator drive
    // One-hot drive per band; codes above the top band and non-resonator
    // sources give no drive, since nothing defines a current for them.
    assign resonator_band =
        cfg_ob1_r[option_cfg_pkg::OB1_BAND_HI:option_cfg_pkg::OB1_BAND_LO];
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_drive
        assign resonator_drive[gi] = sel_resonator && (resonator_band == 3'(gi));
    end

    // The doubler is not checked against the source here; the tool keeps it legal.
    // doubler control
    assign doubler_enable = !cfg_ob1_r[option_cfg_pkg::OB1_PLL_OFF_BIT];

endmodule

// >>> design/option_cfg_pkg.sv
// Package for the option byte configuration block: field positions, defaults and codes.
// Assumes a single core clock and a programming port driven by an outside tool.
package option_cfg_pkg;

    // ****************************************************************
    // Field positions in the first option byte.
    // ****************************************************************
    localparam int OB0_WATCHDOG_HALT_RESET_OPT_BIT = 7;
    localparam int OB0_WDG_TYPE_BIT = 6;
    localparam int OB0_RSVD_HI_BIT = 5;
    localparam int OB0_VD_HI = 4;
    localparam int OB0_VD_LO = 3;
    localparam int OB0_RSVD_LO_HI = 2;
    localparam int OB0_RSVD_LO_LO = 1;
    localparam int OB0_PROT_BIT = 0;

    // ****************************************************************
    // Field positions in the second option byte.
    // ****************************************************************
    localparam int OB1_PKG_BIT = 7;
    localparam int OB1_RESET_DELAY_SELECT_BIT = 6;
    localparam int OB1_CLK_HI = 5;
    localparam int OB1_CLK_LO = 4;
    localparam int OB1_BAND_HI = 3;
    localparam int OB1_BAND_LO = 1;
    localparam int OB1_PLL_OFF_BIT = 0;

    // ****************************************************************
    // Erased values and byte selects on the programming port.
    // ****************************************************************
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] OB0_DEFAULT = 8'he7;
    localparam logic [7:0] OB1_DEFAULT_LOW7 = 8'h67;
    localparam logic OPT_SEL_ZERO = 1'b0;
    localparam logic OPT_SEL_ONE = 1'b1;

    // ****************************************************************
    // Field codes.
    // ****************************************************************
    localparam logic [1:0] VD_HIGH = 2'h0;
    localparam logic [1:0] VD_MEDIUM = 2'h1;
    localparam logic [1:0] VD_LOW = 2'h2;
    localparam logic [1:0] VD_OFF = 2'h3;
    localparam logic [1:0] CLK_RESONATOR = 2'h0;
    localparam logic [1:0] CLK_RESERVED = 2'h1;
    localparam logic [1:0] CLK_INTERNAL_RC = 2'h2;
    localparam logic [1:0] CLK_EXTERNAL = 2'h3;
    localparam logic [2:0] BAND_ONE_TO_TWO = 3'h0;
    localparam logic [2:0] BAND_TWO_TO_FOUR = 3'h1;
    localparam logic [2:0] BAND_FOUR_TO_EIGHT = 3'h2;
    localparam logic [2:0] BAND_EIGHT_TO_SIXTEEN = 3'h3;

    // ****************************************************************
    // Reset phase lengths in CPU cycles.
    // ****************************************************************
    localparam int RESET_CYCLES_LONG = 4096;
    localparam int RESET_CYCLES_SHORT = 256;
    localparam int RESET_CNT_W = 13;

endpackage

// >>> design/reset_phase_counter.sv
// Reset phase counter: counts the reset delay after reset and after Halt exit.
// Assumes the length select is stable while a count is running.
`timescale 1ns/1ns
module reset_phase_counter #(
    parameter int LONG_CYCLES = option_cfg_pkg::RESET_CYCLES_LONG,
    parameter int SHORT_CYCLES = option_cfg_pkg::RESET_CYCLES_SHORT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic use_short,
    output logic busy
);

    localparam int W = option_cfg_pkg::RESET_CNT_W;

    // ****************************************************************
    // Elaboration check.
    // ****************************************************************
    if (LONG_CYCLES < 1 || SHORT_CYCLES < 1 || LONG_CYCLES >= (1 << W) ||
        SHORT_CYCLES >= (1 << W)) begin : g_bad
        $error("Reset phase length does not fit the counter.");
    end

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] load_val;

    // The loaded value picks the phase length; counting stops at zero.
    assign load_val = use_short ? W'(SHORT_CYCLES) : W'(LONG_CYCLES);
    assign cnt_nxt = start ? load_val : ((cnt_r != '0) ? cnt_r - W'(1) : cnt_r);
    assign busy = (cnt_r != '0);

    // Counter register; reset leaves it idle so the start pulse decides the length.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// >>> verification/opt_cfg_properties.sv
// Checker for the option byte block, bound to its top module.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ns
module opt_cfg_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic prog_mode,
    input wire logic opt_rd,
    input wire logic opt_erase,
    input wire logic [7:0] opt_rdata,
    input wire logic opt_busy,
    input wire logic mem_erase_req,
    input wire logic mem_erase_done,
    input wire logic halt_entry,
    input wire logic watchdog_running,
    input wire logic watchdog_halt_reset,
    input wire logic [1:0] voltage_detect_level,
    input wire logic low_supply_reset_detector_en,
    input wire logic auxiliary_supply_detector_en,
    input wire logic readout_block,
    input wire logic [1:0] clock_source_type,
    input wire logic sel_resonator,
    input wire logic [2:0] resonator_band,
    input wire logic [3:0] resonator_drive,
    input wire logic reset_delay_select,
    input wire logic reset_phase_active
);
    // ****************************************************************
    // Helper logic and properties.
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Length of the current reset phase run, so a long count needs no repetition.
    logic [12:0] run_r;
    logic [12:0] run_nxt;
    assign run_nxt = reset_phase_active ? run_r + 13'h1 : 13'h0;
    always_ff @(posedge core_clk) begin
        run_r <= rst ? 13'h0 : run_nxt;
    end
    property p_halt_reset;
        watchdog_halt_reset |-> $past(halt_entry && watchdog_running);
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halt reset without cause");
    property p_detectors;
        low_supply_reset_detector_en == (voltage_detect_level != 2'h3)
            && auxiliary_supply_detector_en == low_supply_reset_detector_en;
    endproperty
    a_detectors: assert property (p_detectors) else $error("detector enable wrong");
    property p_wipe_start;
        $rose(mem_erase_req) |-> $past(opt_erase && prog_mode) && opt_busy;
    endproperty
    a_wipe_start: assert property (p_wipe_start) else $error("wipe request without erase");
    property p_wipe_hold;
        mem_erase_req && !mem_erase_done |=> mem_erase_req;
    endproperty
    a_wipe_hold: assert property (p_wipe_hold) else $error("wipe request dropped early");
    property p_read_idle;
        !$past(opt_rd && prog_mode) |-> opt_rdata == 8'hff;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without read");
    // Decoded settings may only move in the two cycles after a reset.
    property p_hold;
        !$past(rst) && !$past(rst, 2) |-> $stable({voltage_detect_level, readout_block,
            clock_source_type, resonator_band, reset_delay_select});
    endproperty
    a_hold: assert property (p_hold) else $error("decoded setting changed");
    property p_phase_len;
        $fell(reset_phase_active) |-> run_r == (reset_delay_select ? 13'h100 : 13'h1000);
    endproperty
    a_phase_len: assert property (p_phase_len) else $error("reset phase length wrong");
    property p_drive;
        resonator_drive == ((sel_resonator && !resonator_band[2]) ?
            4'h1 << resonator_band[1:0] : 4'h0);
    endproperty
    a_drive: assert property (p_drive) else $error("resonator drive wrong");
    c_long_phase: cover property ($fell(reset_phase_active) && !reset_delay_select);
    c_halt_reset: cover property (watchdog_halt_reset);
    c_wipe_end: cover property ($fell(mem_erase_req));
endmodule
bind option_byte_config_decode opt_cfg_properties u_props (.*);

// >>> verification/wipe_responder.sv
// Model of the program memory wipe behind the protected option erase.
// Assumes the block holds its wipe request as a level until answered.
`timescale 1ns/1ns
module wipe_responder (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic mem_erase_req,
    input wire logic [7:0] wait_cycles,
    output logic mem_erase_done
);
    // ****************************************************************
    // Wipe timing.
    // ****************************************************************
    logic [7:0] cnt_r;
    // wipe takes time
    // Zero answers at once; larger values stall the block like a slow array.
    always_ff @(posedge core_clk) begin
        cnt_r <= (rst || !mem_erase_req) ? 8'h00 : cnt_r + 8'h01;
    end
    // Done shows only while the request stands, never after it is released.
    assign mem_erase_done = mem_erase_req && cnt_r == wait_cycles;
endmodule

// >>> verification/tb.sv
// Self-checking bench for the option byte block with a wipe responder.
// Assumes the default non-mask build and a 125 MHz core clock.
`timescale 1ns/1ns
module tb;
    // ****************************************************************
    // Stimulus, checks and verdict.
    // ****************************************************************
    logic core_clk, rst, prog_mode, opt_sel, opt_wr, opt_erase, opt_rd, opt_busy;
    logic mem_erase_req, mem_erase_done, halt_entry, halt_exit, watchdog_running;
    logic watchdog_halt_reset, watchdog_force_on, low_supply_reset_detector_en;
    logic auxiliary_supply_detector_en, readout_block, memory_write_block;
    logic package_select_opt, sel_resonator, sel_internal_rc, sel_external_clk;
    logic doubler_enable, reset_delay_select, reset_phase_active;
    logic [7:0] opt_wdata, opt_rdata, pad_bonded, pad_pullup_force, wait_cycles;
    logic [1:0] voltage_detect_level, clock_source_type;
    logic [2:0] resonator_band;
    logic [3:0] resonator_drive;
    logic [15:0] tbl [5];
    int errors, cmp_count, cycles;
    option_byte_config_decode dut (.*);
    wipe_responder u_wipe (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One strobe cycle; k is {halt_exit, halt_entry, erase, read, write}.
    task automatic strobe(input logic [4:0] k, input logic s, input logic [7:0] d);
        @(posedge core_clk);
        {halt_exit, halt_entry, opt_erase, opt_rd, opt_wr} <= k;
        opt_sel <= s;
        opt_wdata <= d;
        @(posedge core_clk);
        {halt_exit, halt_entry, opt_erase, opt_rd, opt_wr} <= 5'h00;
        #1;
    endtask
    task automatic do_rst();
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    // Counts the cycles the reset phase stays high once it has started.
    task automatic phase(input logic short_sel);
        int n;
        int e;
        n = 0;
        e = short_sel ? 256 : 4096;
        #1;
        for (int i = 0; i < 5000 && (n == 0 || reset_phase_active === 1'b1); i++) begin
            if (reset_phase_active === 1'b1) n++;
            #8;
        end
        chk(16'(n), 16'(e));
    endtask
    task automatic check_all(input logic [7:0] b0, input logic [7:0] b1);
        logic [1:0] c;
        c = b1[5:4];
        repeat (2) @(posedge core_clk);
        #1;
        chk(watchdog_force_on, !b0[6]);
        chk(voltage_detect_level, b0[4:3]);
        chk({low_supply_reset_detector_en, auxiliary_supply_detector_en}, {2{b0[4:3] != 2'h3}});
        chk({readout_block, memory_write_block}, {2{~b0[0]}});
        chk(package_select_opt, b1[7]);
        chk(pad_pullup_force, 8'(~pad_bonded));
        chk(clock_source_type, c);
        chk({sel_resonator, sel_internal_rc, sel_external_clk}, {c == 2'h0, c == 2'h2, c == 2'h3});
        chk(resonator_band, b1[3:1]);
        chk(resonator_drive, (c == 2'h0 && !b1[3]) ? 4'h1 << b1[2:1] : 4'h0);
        chk(doubler_enable, !b1[0]);
        chk(reset_delay_select, b1[6]);
        phase(b1[6]);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // A hung wait ends the run as a failure.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {rst, prog_mode} = 2'h3;
        {opt_sel, opt_wr, opt_erase, opt_rd, halt_entry, halt_exit, watchdog_running} = 7'h00;
        {opt_wdata, pad_bonded, wait_cycles} = 24'h000000;
        {errors, cmp_count, cycles} = 0;
        tbl = '{16'haf87, 16'h7772, 16'hffe3, 16'he7d5, 16'h2602};
        do_rst();
        check_all(8'he7, 8'he7);
        chk(opt_rdata, 8'hff);
        // Outside programming mode the bytes are neither written nor shown.
        @(posedge core_clk) prog_mode <= 1'b0;
        strobe(5'h01, 1'b0, 8'h00);
        strobe(5'h02, 1'b0, 8'h00);
        chk(opt_rdata, 8'hff);
        @(posedge core_clk) prog_mode <= 1'b1;
        strobe(5'h02, 1'b0, 8'h00);
        chk(opt_rdata, 8'he7);
        foreach (tbl[i]) begin
            strobe(5'h01, 1'b0, tbl[i][15:8]);
            strobe(5'h01, 1'b1, tbl[i][7:0]);
            strobe(5'h02, 1'b0, 8'h00);
            chk(opt_rdata, tbl[i][15:8]);
            strobe(5'h02, 1'b1, 8'h00);
            chk(opt_rdata, tbl[i][7:0]);
            @(posedge core_clk) pad_bonded <= tbl[i][15:8];
            do_rst();
            check_all(tbl[i][15:8], tbl[i][7:0]);
            for (int j = 0; j < 2; j++) begin
                @(posedge core_clk) watchdog_running <= j[0];
                strobe(5'h08, 1'b0, 8'h00);
                chk(watchdog_halt_reset, tbl[i][15] & j[0]);
            end
            strobe(5'h10, 1'b0, 8'h00);
            phase(tbl[i][6]);
        end
        // Protected erase wipes memory first; a write while busy is refused.
        @(posedge core_clk) wait_cycles <= 8'h14;
        strobe(5'h04, 1'b0, 8'h00);
        chk({opt_busy, mem_erase_req}, 2'h3);
        strobe(5'h01, 1'b0, 8'h00);
        repeat (60) if (opt_busy === 1'b1) #8;
        strobe(5'h02, 1'b0, 8'h00);
        chk(opt_rdata, 8'he7);
        strobe(5'h02, 1'b1, 8'h00);
        chk(opt_rdata, 8'he7);
        strobe(5'h04, 1'b0, 8'h00);
        chk(mem_erase_req, 1'b0);
        repeat (8) if (opt_busy === 1'b1) #8;
        give_verdict();
    end
endmodule
